// file: verilog/pao_pkg.sv
// shared constants for the phase accumulator oscillator
package pao_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLK = 8'h04;
  localparam logic [7:0] ADDR_ACCL = 8'h08;
  localparam logic [7:0] ADDR_ACCH = 8'h0c;
  localparam logic [7:0] ADDR_ACCU = 8'h10;
  localparam logic [7:0] ADDR_INCL = 8'h14;
  localparam logic [7:0] ADDR_INCH = 8'h18;
  localparam logic [7:0] ADDR_INCU = 8'h1c;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_PIN_BIT = 4;
  localparam int CTRL_PULSE_BIT = 0;
  localparam int PWS_LSB = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CLK_RESET = 8'h00;
  localparam logic [19:0] ACC_RESET = 20'h00000;
  localparam logic [19:0] INC_RESET = 20'h00000;
  localparam int ACC_W = 20;
  localparam int NUM_SRC = 11;
  // ----------------------------------------
  // clock source codes
  // ----------------------------------------
  localparam logic [3:0] CKS_SYSCLK = 4'h0;
  localparam logic [3:0] CKS_LAST = 4'ha;
  // second rising input edge after a low increment write
  localparam logic [1:0] INC_LOAD_EDGES = 2'h2;
endpackage

// file: verilog/pao_sync.sv
// two flip-flop synchronisers for the clock source inputs
`timescale 1ns/1ps
module pao_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pao_pkg::NUM_SRC-1:0] async_in,
  output logic [pao_pkg::NUM_SRC-1:0] sync_out
);
  typedef struct packed {
    logic [pao_pkg::NUM_SRC-1:0] meta;
    logic [pao_pkg::NUM_SRC-1:0] stable;
  } pao_sync_t;
  pao_sync_t s_reg;
  pao_sync_t s_next;

  // ----------------------------------------
  // per bit stages
  // ----------------------------------------
  // first stage feeds only the second stage
  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < pao_pkg::NUM_SRC; i++) begin
      s_next.meta[i] = async_in[i];
      s_next.stable[i] = s_reg.meta[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;
endmodule

// file: verilog/pao_top.sv
// phase accumulator oscillator with apb register access
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - add buffered increment at input clock rate; carry is raw output pulse
// - 20-bit accumulator, overflow rate is input rate times increment over 2^20
// - accumulator readable and writable as low, high and upper bytes
// - each input edge while enabled loads accumulator with previous value plus increment
// - 20-bit increment in low, high and upper byte registers
// - enabled: low increment write loads buffers on second input edge after
// - increment double buffered; inner buffer not visible to software
// - disabled: any increment write loads buffers at once
// - output stretched or toggled, sent inside and optionally to a pin
// - every overflow raises an interrupt request
// - pulse width field bits 7-5 holds output for 2^n input periods
// - pulse width applies only in pulse frequency mode
// - clock source field bits 3-0 picks input clock; 1011-1111 reserved
// - output period moves in whole input periods, average gives frequency
module pao_top (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [pao_pkg::NUM_SRC-1:0] CLK_SRC_IN,
  output logic NCO_OUT,
  output logic PIN_OUT,
  output logic PIN_OE_N,
  output logic OVF_IRQ
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] clk_sel;
    logic [19:0] acc;
    logic [19:0] inc_stage;
    logic [19:0] inc_buf;
    logic load_pend;
    logic [1:0] load_cnt;
    logic src_prev;
    logic out_lvl;
    logic [6:0] width_cnt;
    logic irq;
    logic pin;
    logic pin_oe_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pao_state_t;

  pao_state_t s_reg;
  pao_state_t s_next;
  logic [pao_pkg::NUM_SRC-1:0] src_sync;
  logic src_lvl;
  logic in_edge;
  logic [20:0] sum;
  logic ovf;
  logic enabled;
  logic wr;
  logic rd_phase;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [2:0] pws;

  pao_sync u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .async_in(CLK_SRC_IN),
    .sync_out(src_sync)
  );

  // ----------------------------------------
  // input clock selection
  // ----------------------------------------
  // external sources are seen as edges of a synced level, so they must run
  // well below half the system clock rate
  always_comb begin
    src_lvl = 1'b0;
    if (s_reg.clk_sel[3:0] != pao_pkg::CKS_SYSCLK &&
        s_reg.clk_sel[3:0] <= pao_pkg::CKS_LAST) begin
      src_lvl = src_sync[s_reg.clk_sel[3:0] - 4'h1];
    end
  end

  assign in_edge = (s_reg.clk_sel[3:0] == pao_pkg::CKS_SYSCLK) ? 1'b1 :
                   (src_lvl & ~s_reg.src_prev);
  assign enabled = s_reg.ctrl[pao_pkg::CTRL_EN_BIT];
  // combinational full adder, independent of the input clock
  assign sum = {1'b0, s_reg.acc} + {1'b0, s_reg.inc_buf};
  assign ovf = enabled & in_edge & sum[20];
  assign pws = s_reg.clk_sel[7:pao_pkg::PWS_LSB];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign wr = PSEL & PENABLE & PWRITE & s_reg.pready;
  assign rd_phase = PSEL & PENABLE & ~s_reg.pready;
  assign wbyte = PWDATA[7:0];
  always_comb begin
    mapped = 1'b1;
    rbyte = 8'h00;
    unique case (PADDR)
      pao_pkg::ADDR_CTRL: rbyte = {s_reg.ctrl[7:6], s_reg.out_lvl, s_reg.ctrl[4:0]};
      pao_pkg::ADDR_CLK: rbyte = {s_reg.clk_sel[7:5], 1'b0, s_reg.clk_sel[3:0]};
      pao_pkg::ADDR_ACCL: rbyte = s_reg.acc[7:0];
      pao_pkg::ADDR_ACCH: rbyte = s_reg.acc[15:8];
      pao_pkg::ADDR_ACCU: rbyte = {4'h0, s_reg.acc[19:16]};
      pao_pkg::ADDR_INCL: rbyte = s_reg.inc_stage[7:0];
      pao_pkg::ADDR_INCH: rbyte = s_reg.inc_stage[15:8];
      pao_pkg::ADDR_INCU: rbyte = {4'h0, s_reg.inc_stage[19:16]};
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.src_prev = src_lvl;
    s_next.irq = ovf;

    // accumulate, keeping the remainder on overflow
    if (enabled && in_edge) begin
      s_next.acc = sum[19:0];
    end

    // commit of the staged increment while running
    if (s_reg.load_pend && enabled && in_edge) begin
      s_next.load_cnt = s_reg.load_cnt + 2'h1;
      if (s_reg.load_cnt + 2'h1 == pao_pkg::INC_LOAD_EDGES) begin
        s_next.inc_buf = s_reg.inc_stage;
        s_next.load_pend = 1'b0;
      end
    end
    if (!enabled) begin
      s_next.load_pend = 1'b0;
    end

    // output shaping, period moves in whole input edges
    if (s_reg.ctrl[pao_pkg::CTRL_PULSE_BIT]) begin
      if (ovf) begin
        s_next.out_lvl = 1'b1;
        s_next.width_cnt = 7'((8'h01 << pws) - 8'h01);
      end else if (enabled && in_edge && s_reg.out_lvl) begin
        if (s_reg.width_cnt == 7'h00) begin
          s_next.out_lvl = 1'b0;
        end else begin
          s_next.width_cnt = s_reg.width_cnt - 7'h01;
        end
      end
    end else if (ovf) begin
      s_next.out_lvl = ~s_reg.out_lvl;
    end

    // register writes take effect at the edge where pready is seen high
    if (wr && mapped) begin
      unique case (PADDR)
        pao_pkg::ADDR_CTRL: s_next.ctrl = {wbyte[7:6], 1'b0, wbyte[4:0]};
        pao_pkg::ADDR_CLK: s_next.clk_sel = {wbyte[7:5], 1'b0, wbyte[3:0]};
        pao_pkg::ADDR_ACCL: s_next.acc[7:0] = wbyte;
        pao_pkg::ADDR_ACCH: s_next.acc[15:8] = wbyte;
        pao_pkg::ADDR_ACCU: s_next.acc[19:16] = wbyte[3:0];
        pao_pkg::ADDR_INCL: s_next.inc_stage[7:0] = wbyte;
        pao_pkg::ADDR_INCH: s_next.inc_stage[15:8] = wbyte;
        pao_pkg::ADDR_INCU: s_next.inc_stage[19:16] = wbyte[3:0];
        default: s_next.ctrl = s_reg.ctrl;
      endcase
      if (PADDR == pao_pkg::ADDR_INCL || PADDR == pao_pkg::ADDR_INCH ||
          PADDR == pao_pkg::ADDR_INCU) begin
        if (!enabled) begin
          s_next.inc_buf = s_next.inc_stage;
        end else if (PADDR == pao_pkg::ADDR_INCL) begin
          // a fresh low write restarts the edge count
          s_next.load_pend = 1'b1;
          s_next.load_cnt = 2'h0;
        end
      end
    end

    // pin driver follows the shaped output
    s_next.pin = s_next.out_lvl & s_next.ctrl[pao_pkg::CTRL_PIN_BIT];
    s_next.pin_oe_n = ~s_next.ctrl[pao_pkg::CTRL_PIN_BIT];

    // one wait state, so every bus output comes from a flip-flop
    s_next.pready = rd_phase;
    s_next.pslverr = rd_phase & ~mapped;
    s_next.prdata = (rd_phase && !PWRITE) ? {24'h000000, rbyte} : 32'h00000000;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
      s_reg.ctrl <= pao_pkg::CTRL_RESET;
      s_reg.clk_sel <= pao_pkg::CLK_RESET;
      s_reg.acc <= pao_pkg::ACC_RESET;
      s_reg.inc_stage <= pao_pkg::INC_RESET;
      s_reg.inc_buf <= pao_pkg::INC_RESET;
      s_reg.pin_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign NCO_OUT = s_reg.out_lvl;
  assign PIN_OUT = s_reg.pin;
  assign PIN_OE_N = s_reg.pin_oe_n;
  assign OVF_IRQ = s_reg.irq;
endmodule

// file: bench/pao_chk.sv
// port checker for the phase accumulator oscillator
`timescale 1ns/1ps
module pao_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic NCO_OUT,
  input wire logic PIN_OE_N,
  input wire logic OVF_IRQ
);
  // ----------------------------------------
  // bus and output relations
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  a_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error without ready");
  a_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  a_byte_only: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data above the byte");
  a_upper_nibble: assert property (PREADY && !PWRITE && (PADDR == pao_pkg::ADDR_ACCU ||
    PADDR == pao_pkg::ADDR_INCU) |-> PRDATA[7:4] == 4'h0)
    else $error("upper nibble not zero");
  a_clk_gap: assert property (PREADY && !PWRITE && PADDR == pao_pkg::ADDR_CLK |-> !PRDATA[4])
    else $error("clock bit 4 not zero");
  a_rise_irq: assert property ($rose(NCO_OUT) |-> OVF_IRQ)
    else $error("output rose without overflow");
  a_reset_idle: assert property (disable iff (1'b0) !RST_N |=> PIN_OE_N && !NCO_OUT)
    else $error("outputs not idle in reset");
endmodule
bind pao_top pao_chk chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .NCO_OUT(NCO_OUT), .PIN_OE_N(PIN_OE_N), .OVF_IRQ(OVF_IRQ));

// file: bench/phase_accumulator_oscillator_bench.sv
// self-checking bench for the phase accumulator oscillator
`timescale 1ns/1ps
module phase_accumulator_oscillator_bench;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [pao_pkg::NUM_SRC-1:0] CLK_SRC_IN = '0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic NCO_OUT;
  logic PIN_OUT;
  logic PIN_OE_N;
  logic OVF_IRQ;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_ovf = 0;
  pao_top uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CLK_SRC_IN(CLK_SRC_IN), .NCO_OUT(NCO_OUT), .PIN_OUT(PIN_OUT),
    .PIN_OE_N(PIN_OE_N), .OVF_IRQ(OVF_IRQ));
  always #4 SYS_CLK = ~SYS_CLK;
  // ----------------------------------------
  // cycle limit and overflow monitor
  // ----------------------------------------
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (OVF_IRQ === 1'b1) n_ovf <= n_ovf + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  // ----------------------------------------
  // bus and source drivers
  // ----------------------------------------
  // the wait loop is bounded only by the cycle limit above; reads just after
  // an edge see the values that stood at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  // upper nibble of the top byte is always set, so ignored bits get written too
  task automatic acc_set(input logic [19:0] v);
    wr(pao_pkg::ADDR_ACCU, {4'hf, v[19:16]});
    wr(pao_pkg::ADDR_ACCH, v[15:8]);
    wr(pao_pkg::ADDR_ACCL, v[7:0]);
  endtask
  task automatic acc_chk(input logic [19:0] v);
    rd(pao_pkg::ADDR_ACCL, {24'h0, v[7:0]});
    rd(pao_pkg::ADDR_ACCH, {24'h0, v[15:8]});
    rd(pao_pkg::ADDR_ACCU, {28'h0, v[19:16]});
  endtask
  // one slow source edge; ten cycles cover the two-cycle synchroniser
  task automatic src(input logic [pao_pkg::NUM_SRC-1:0] m);
    @(posedge SYS_CLK);
    CLK_SRC_IN <= m;
    repeat (4) @(posedge SYS_CLK);
    CLK_SRC_IN <= '0;
    repeat (6) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask
  task automatic rst();
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    rd(8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
  endtask
  task automatic t_wrap();
    wr(pao_pkg::ADDR_CLK, 8'h21);
    rd(pao_pkg::ADDR_CLK, 32'h21);
    wr(pao_pkg::ADDR_INCU, 8'hf0);
    rd(pao_pkg::ADDR_INCU, 32'h0);
    wr(pao_pkg::ADDR_INCL, 8'h10);
    acc_set(20'hffff8);
    wr(pao_pkg::ADDR_CTRL, 8'h80);
    src(11'h001);
    acc_chk(20'h00008);
    chk("overflows", 32'h1, n_ovf);
    chk("nco out", 32'h1, NCO_OUT);
  endtask
  task automatic t_commit();
    wr(pao_pkg::ADDR_INCH, 8'h01);
    src(11'h001);
    acc_chk(20'h00018);
    rd(pao_pkg::ADDR_INCH, 32'h01);
    wr(pao_pkg::ADDR_INCL, 8'h00);
    src(11'h001);
    src(11'h001);
    acc_chk(20'h00038);
    src(11'h001);
    acc_chk(20'h00138);
    chk("toggle hold", 32'h1, NCO_OUT);
  endtask
  // code 11 is reserved: every source pulses and nothing may count
  task automatic t_select();
    for (int c = 1; c <= 11; c++) begin
      wr(pao_pkg::ADDR_CTRL, 8'h00);
      wr(pao_pkg::ADDR_CLK, 8'(c));
      wr(pao_pkg::ADDR_INCL, 8'h01);
      acc_set(20'h0);
      wr(pao_pkg::ADDR_CTRL, 8'h80);
      src(c <= 10 ? ~(11'h1 << (c - 1)) : 11'h7ff);
      src(c <= 10 ? 11'h1 << (c - 1) : 11'h000);
      acc_chk(c <= 10 ? 20'h00101 : 20'h0);
    end
  endtask
  // system clock code: one add per cycle from the enable write edge to the
  // disable write edge, four cycles apart with one wait state and one idle
  task automatic t_sysclk();
    wr(pao_pkg::ADDR_CTRL, 8'h00);
    wr(pao_pkg::ADDR_CLK, 8'h00);
    acc_set(20'h0);
    wr(pao_pkg::ADDR_CTRL, 8'h80);
    wr(pao_pkg::ADDR_CTRL, 8'h00);
    acc_chk(20'h00404);
  endtask
  // widths of 1 to 4 edges stay far below the 2^16-edge overflow period
  task automatic t_pulse();
    for (int p = 0; p < 3; p++) begin
      wr(pao_pkg::ADDR_CTRL, 8'h00);
      wr(pao_pkg::ADDR_CLK, {3'(p), 5'h01});
      wr(pao_pkg::ADDR_INCL, 8'h10);
      acc_set(20'hffff8);
      wr(pao_pkg::ADDR_CTRL, 8'h91);
      src(11'h001);
      chk("pin out", 32'h1, PIN_OUT);
      chk("pin oe", 32'h0, PIN_OE_N);
      repeat ((1 << p) - 1) src(11'h001);
      chk("pulse high", 32'h1, NCO_OUT);
      src(11'h001);
      chk("pulse low", 32'h0, NCO_OUT);
    end
  endtask
  initial begin
    rst();
    t_regs();
    t_wrap();
    t_commit();
    t_select();
    t_sysclk();
    rst();
    t_pulse();
    stop_test();
  end
endmodule
